// ---- logic/dctc_regs.svh ----
`ifndef DCTC_REGS_SVH
`define DCTC_REGS_SVH
`define DCTC_AW 8
`define DCTC_NBANK 8
`define DCTC_TIM_OFS 8'h00
`define DCTC_CFG_OFS 8'h04
`define DCTC_RFI_OFS 8'h08
`define DCTC_STAT_OFS 8'h0C
`define DCTC_RFC 31:25
`define DCTC_RP 24:22
`define DCTC_RCD 21:19
`define DCTC_WR 18:16
`define DCTC_RAS 15:11
`define DCTC_RC 10:6
`define DCTC_RRD 5:3
`define DCTC_WTR 1:0
`define DCTC_EN_BIT 0
`define DCTC_UNLK_BIT 15
`define DCTC_TIM_RST 32'h7FFF_FFFB
`define DCTC_TIM_WMASK 32'hFFFF_FFFB
`define DCTC_RFI_RST 16'h0618
`define DCTC_RFI_MIN 16'h0100
`define DCTC_RESP_OK 2'h0
`define DCTC_RESP_ERR 2'h2
`define DCTC_GAP_MAX 8'hFF
`endif

// ---- logic/dctc_pkg.sv ----
package dctc_pkg;
  typedef enum logic [2:0] {
    OP_NOP,
    OP_REFRESH,
    OP_LOAD_MODE,
    OP_ACTIVATE,
    OP_PRECHARGE,
    OP_READ,
    OP_WRITE
  } dctc_op_t;

  typedef struct packed {
    logic valid;
    dctc_op_t op;
    logic [2:0] bank;
  } dctc_req_t;

  typedef struct packed {
    dctc_op_t op;
    logic [2:0] bank;
  } dctc_mcmd_t;
endpackage : dctc_pkg

// ---- logic/dctc_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module dctc_timer #(
  parameter int W = 3
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt;

  // Loading the raw field gives a gap of field plus one cycles before done returns.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= value;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign done = (cnt == '0);
endmodule : dctc_timer
`default_nettype wire

// ---- logic/dctc_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dctc_regs.svh"
module dctc_core
  import dctc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [`DCTC_AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [`DCTC_AW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire dctc_req_t req,
  output logic req_grant,
  output dctc_mcmd_t mem_cmd,
  output logic mem_cmd_valid,
  output logic init_start,
  output logic memory_interface_enable,
  output logic [15:0] refresh_interval
);
  logic [31:0] sdram_timing_one;
  logic timing_write_unlock;
  logic [`DCTC_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction : merge

  function automatic logic [7:0] gap_next(input logic start, input logic [7:0] g);
    return start ? 8'h01 : ((g == `DCTC_GAP_MAX) ? g : g + 8'h01);
  endfunction : gap_next

  // Write path: address and data are caught in either order, then applied together.
  wire logic aw_take = s_awvalid && s_awready;
  wire logic w_take = s_wvalid && s_wready;
  wire logic wr_go = !s_awready && !s_wready && !s_bvalid;
  wire logic sel_tim = aw_addr == `DCTC_TIM_OFS;
  wire logic sel_cfg = aw_addr == `DCTC_CFG_OFS;
  wire logic sel_rfi = aw_addr == `DCTC_RFI_OFS;
  wire logic wr_map = sel_tim || sel_cfg || sel_rfi || (aw_addr == `DCTC_STAT_OFS);
  wire logic [31:0] tim_merge = merge(sdram_timing_one, w_data, w_strb) & `DCTC_TIM_WMASK;
  wire logic tim_we = wr_go && sel_tim && timing_write_unlock;
  wire logic [31:0] cfg_merge = merge({16'h0000, timing_write_unlock, 14'h0000,
                                       memory_interface_enable}, w_data, w_strb);
  wire logic [31:0] rfi_word = merge({16'h0000, refresh_interval}, w_data, w_strb);
  wire logic [15:0] rfi_merge = rfi_word[15:0];
  wire logic [15:0] rfi_floor = {8'h00, sdram_timing_one[`DCTC_RFC], 1'b0};
  wire logic [15:0] next_rfi = (rfi_merge < `DCTC_RFI_MIN) ? rfi_floor : rfi_merge;
  wire logic wr_kick = tim_we && memory_interface_enable &&
                       (tim_merge[`DCTC_WR] != sdram_timing_one[`DCTC_WR]);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= `DCTC_RESP_OK;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (aw_take) begin
        s_awready <= 1'b0;
        aw_addr <= s_awaddr;
      end
      if (w_take) begin
        s_wready <= 1'b0;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_map ? `DCTC_RESP_OK : `DCTC_RESP_ERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sdram_timing_one <= `DCTC_TIM_RST;
      timing_write_unlock <= 1'b0;
      memory_interface_enable <= 1'b0;
      refresh_interval <= `DCTC_RFI_RST;
      init_start <= 1'b0;
    end else begin
      init_start <= wr_kick;
      if (tim_we) begin
        sdram_timing_one <= tim_merge;
      end
      if (wr_go && sel_cfg) begin
        timing_write_unlock <= cfg_merge[`DCTC_UNLK_BIT];
        memory_interface_enable <= cfg_merge[`DCTC_EN_BIT];
      end
      if (wr_go && sel_rfi) begin
        refresh_interval <= next_rfi;
      end
    end
  end

  // Command spacing.
  logic rfc_ok, rp_ok, rrd_ok, wr_ok, wtr_ok;
  logic [`DCTC_NBANK-1:0] rcd_ok, ras_ok, rc_ok;
  wire logic is_rf = req.op == OP_REFRESH;
  wire logic is_act = req.op == OP_ACTIVATE;
  wire logic is_pre = req.op == OP_PRECHARGE;
  wire logic is_rd = req.op == OP_READ;
  wire logic is_wr = req.op == OP_WRITE;
  wire logic is_lm = req.op == OP_LOAD_MODE;
  wire logic op_ok = is_rf ? (rfc_ok && rp_ok) :
                     is_act ? (rfc_ok && rp_ok && rrd_ok && rc_ok[req.bank]) :
                     is_pre ? (wr_ok && ras_ok[req.bank]) :
                     is_rd ? (rcd_ok[req.bank] && wtr_ok) :
                     is_wr ? rcd_ok[req.bank] : 1'b1;
  // Grant is a pulse; blocking on it keeps a held request from firing on two cycles in a row.
  wire logic fire = req.valid && (req.op != OP_NOP) && op_ok && !req_grant;
  wire logic fire_rf = fire && (is_rf || is_lm);
  wire logic fire_act = fire && is_act;
  wire logic fire_pre = fire && is_pre;
  wire logic fire_wr = fire && is_wr;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      req_grant <= 1'b0;
      mem_cmd_valid <= 1'b0;
      mem_cmd <= '{op: OP_NOP, bank: 3'h0};
    end else begin
      req_grant <= fire;
      mem_cmd_valid <= fire;
      if (fire) begin
        mem_cmd <= '{op: req.op, bank: req.bank};
      end
    end
  end

  dctc_timer #(.W(7)) u_rfc (.clock(clock), .nrst(nrst), .load(fire_rf),
    .value(sdram_timing_one[`DCTC_RFC]), .done(rfc_ok));
  dctc_timer #(.W(3)) u_rp (.clock(clock), .nrst(nrst), .load(fire_pre),
    .value(sdram_timing_one[`DCTC_RP]), .done(rp_ok));
  dctc_timer #(.W(3)) u_rrd (.clock(clock), .nrst(nrst), .load(fire_act),
    .value(sdram_timing_one[`DCTC_RRD]), .done(rrd_ok));
  dctc_timer #(.W(3)) u_wr (.clock(clock), .nrst(nrst), .load(fire_wr),
    .value(sdram_timing_one[`DCTC_WR]), .done(wr_ok));
  dctc_timer #(.W(2)) u_wtr (.clock(clock), .nrst(nrst), .load(fire_wr),
    .value(sdram_timing_one[`DCTC_WTR]), .done(wtr_ok));

  for (genvar b = 0; b < `DCTC_NBANK; b++) begin : g_bank
    wire logic hit = req.bank == 3'(b);
    wire logic act_b = fire_act && hit;
    logic [7:0] gap;
    dctc_timer #(.W(3)) u_rcd (.clock(clock), .nrst(nrst), .load(act_b),
      .value(sdram_timing_one[`DCTC_RCD]), .done(rcd_ok[b]));
    dctc_timer #(.W(5)) u_ras (.clock(clock), .nrst(nrst), .load(act_b),
      .value(sdram_timing_one[`DCTC_RAS]), .done(ras_ok[b]));
    dctc_timer #(.W(5)) u_rc (.clock(clock), .nrst(nrst), .load(act_b),
      .value(sdram_timing_one[`DCTC_RC]), .done(rc_ok[b]));

    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        gap <= `DCTC_GAP_MAX;
      end else begin
        gap <= gap_next(act_b, gap);
      end
    end

    rcd_gap_a: assert property (@(posedge clock) disable iff (!nrst)
      fire && hit && (is_rd || is_wr) |-> gap > sdram_timing_one[`DCTC_RCD])
      else $error("Access issued too soon after activate.");
    ras_gap_a: assert property (@(posedge clock) disable iff (!nrst)
      fire_pre && hit |-> gap > sdram_timing_one[`DCTC_RAS])
      else $error("Precharge issued before row active time.");
    rc_gap_a: assert property (@(posedge clock) disable iff (!nrst)
      act_b |-> gap > sdram_timing_one[`DCTC_RC])
      else $error("Activate issued inside row cycle time.");
  end

  // Read path and status.
  wire logic [31:0] cfg_word = {16'h0000, timing_write_unlock, 14'h0000,
                                memory_interface_enable};
  wire logic [31:0] stat_word = {27'h0000000, wtr_ok, wr_ok, rrd_ok, rp_ok, rfc_ok};
  wire logic rd_tim = s_araddr == `DCTC_TIM_OFS;
  wire logic rd_cfg = s_araddr == `DCTC_CFG_OFS;
  wire logic rd_rfi = s_araddr == `DCTC_RFI_OFS;
  wire logic rd_stat = s_araddr == `DCTC_STAT_OFS;
  wire logic rd_map = rd_tim || rd_cfg || rd_rfi || rd_stat;
  wire logic [31:0] rd_val = rd_tim ? sdram_timing_one :
                             rd_cfg ? cfg_word :
                             rd_rfi ? {16'h0000, refresh_interval} :
                             rd_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= `DCTC_RESP_OK;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rd_val;
      s_rresp <= rd_map ? `DCTC_RESP_OK : `DCTC_RESP_ERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // Cycles since the last refresh or load-mode, precharge, activate and write, only for the checks below.
  logic [7:0] gap_rf, gap_rp, gap_act, gap_wr;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gap_rf <= `DCTC_GAP_MAX;
      gap_rp <= `DCTC_GAP_MAX;
      gap_act <= `DCTC_GAP_MAX;
      gap_wr <= `DCTC_GAP_MAX;
    end else begin
      gap_rf <= gap_next(fire_rf, gap_rf);
      gap_rp <= gap_next(fire_pre, gap_rp);
      gap_act <= gap_next(fire_act, gap_act);
      gap_wr <= gap_next(fire_wr, gap_wr);
    end
  end

  rfc_gap_a: assert property (@(posedge clock) disable iff (!nrst)
    fire && (is_rf || is_act) |-> gap_rf > sdram_timing_one[`DCTC_RFC])
    else $error("Refresh or activate inside refresh cycle time.");
  rp_gap_a: assert property (@(posedge clock) disable iff (!nrst)
    fire && (is_rf || is_act) |-> gap_rp > sdram_timing_one[`DCTC_RP])
    else $error("Refresh or activate inside precharge period.");
  wr_gap_a: assert property (@(posedge clock) disable iff (!nrst)
    fire_pre |-> gap_wr > sdram_timing_one[`DCTC_WR])
    else $error("Precharge inside write recovery.");
  rrd_gap_a: assert property (@(posedge clock) disable iff (!nrst)
    fire_act |-> gap_act > sdram_timing_one[`DCTC_RRD])
    else $error("Activates closer than bank-to-bank spacing.");
  wtr_gap_a: assert property (@(posedge clock) disable iff (!nrst)
    fire && is_rd |-> gap_wr > sdram_timing_one[`DCTC_WTR])
    else $error("Read inside write-to-read spacing.");
  init_kick_a: assert property (@(posedge clock) disable iff (!nrst)
    init_start |-> $past(memory_interface_enable) && $changed(sdram_timing_one[`DCTC_WR]))
    else $error("Initialization started without a recovery change.");
  rsvd_zero_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(s_rvalid) && rd_tim |-> !s_rdata[2])
    else $error("Reserved timing bit seen set.");
  lock_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    !timing_write_unlock |=> $stable(sdram_timing_one))
    else $error("Timing register changed while locked.");
  refr_floor_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_go && sel_rfi && (rfi_merge < `DCTC_RFI_MIN) |=> refresh_interval == $past(rfi_floor))
    else $error("Short refresh interval not replaced by floor.");
  grant_one_a: assert property (@(posedge clock) disable iff (!nrst)
    req_grant |-> mem_cmd_valid ##1 !req_grant)
    else $error("Grant did not come as a single pulse.");

  // Loads and answers are held against the decode itself, so a slip shows at its source.
  tim_load_a: assert property (@(posedge clock) disable iff (!nrst)
    tim_we |=> sdram_timing_one == $past(tim_merge))
    else $error("Unlocked timing write did not land.");
  init_lock_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_go && sel_tim && !timing_write_unlock |=> !init_start)
    else $error("Locked timing write started initialization.");
  refr_keep_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_go && sel_rfi && (rfi_merge >= `DCTC_RFI_MIN) |=> refresh_interval == $past(rfi_merge))
    else $error("Refresh interval not loaded as written.");
  cmd_echo_a: assert property (@(posedge clock) disable iff (!nrst)
    fire |=> mem_cmd_valid && mem_cmd.op == $past(req.op) && mem_cmd.bank == $past(req.bank))
    else $error("Issued command does not match the request.");
  bresp_err_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_go && !wr_map |=> s_bvalid && s_bresp == `DCTC_RESP_ERR)
    else $error("Unmapped write not answered with an error.");
  rresp_err_a: assert property (@(posedge clock) disable iff (!nrst)
    s_arvalid && s_arready && !rd_map |=>
    s_rvalid && s_rresp == `DCTC_RESP_ERR && s_rdata == 32'h0000_0000)
    else $error("Unmapped read not answered with an error.");
endmodule : dctc_core
`default_nettype wire

// ---- tb/dctc_sdram_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dctc_sdram_model
  import dctc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire dctc_mcmd_t mem_cmd,
  input wire logic mem_cmd_valid,
  input wire logic [31:0] tim,
  output int viol
);
  int cyc;
  int t_rfc;
  int t_rp;
  int t_wr;
  int t_act;
  logic [2:0] b_act;
  int t_bank [8];
  task automatic gap(input int last, input int field);
    if (cyc - last <= field) viol++;
  endtask : gap
  // Old stamps sit far back so the first command after reset is always legal.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cyc = 0;
      viol = 0;
      t_rfc = -999;
      t_rp = -999;
      t_wr = -999;
      t_act = -999;
      b_act = 3'h0;
      foreach (t_bank[i]) t_bank[i] = -999;
    end else begin
      cyc++;
      if (mem_cmd_valid) begin
        if (mem_cmd.op inside {OP_REFRESH, OP_ACTIVATE}) begin
          gap(t_rfc, tim[31:25]);
          gap(t_rp, tim[24:22]);
        end
        if (mem_cmd.op inside {OP_READ, OP_WRITE}) gap(t_bank[mem_cmd.bank], tim[21:19]);
        if (mem_cmd.op == OP_READ) gap(t_wr, tim[1:0]);
        if (mem_cmd.op == OP_PRECHARGE) begin
          gap(t_wr, tim[18:16]);
          gap(t_bank[mem_cmd.bank], tim[15:11]);
          t_rp = cyc;
        end
        if (mem_cmd.op == OP_ACTIVATE) begin
          gap(t_bank[mem_cmd.bank], tim[10:6]);
          if (b_act != mem_cmd.bank) gap(t_act, tim[5:3]);
          t_act = cyc;
          b_act = mem_cmd.bank;
          t_bank[mem_cmd.bank] = cyc;
        end
        if (mem_cmd.op inside {OP_REFRESH, OP_LOAD_MODE}) t_rfc = cyc;
        if (mem_cmd.op == OP_WRITE) t_wr = cyc;
      end
    end
  end
endmodule : dctc_sdram_model
`default_nettype wire

// ---- tb/ddr2_command_timing_config_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dctc_regs.svh"
module ddr2_command_timing_config_bench
  import dctc_pkg::*;
;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, grant, mvalid, init_start, en;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] rfi;
  dctc_req_t req = '0;
  dctc_mcmd_t mcmd;
  int fails = 0, comparisons = 0, inits = 0, exp_inits = 0, viol;
  logic [31:0] tim_m = 32'h7FFF_FFFB, cfg_m = 32'h0, rfi_m = 32'h618, t;
  always #12.5 clock = ~clock;
  always @(posedge clock) if (init_start === 1'b1) inits++;
  dctc_core DUT (.clock(clock), .nrst(nrst), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .req(req), .req_grant(grant),
    .mem_cmd(mcmd), .mem_cmd_valid(mvalid), .init_start(init_start),
    .memory_interface_enable(en), .refresh_interval(rfi));
  dctc_sdram_model sdram (.clock(clock), .nrst(nrst), .mem_cmd(mcmd),
    .mem_cmd_valid(mvalid), .tim(tim_m), .viol(viol));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  function automatic logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (s[i]) o[8*i+:8] = d[8*i+:8];
    return o;
  endfunction : merge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] er;
    logic [31:0] nt;
    er = `DCTC_RESP_OK;
    @(posedge clock);
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid, bready} <= 3'b111;
    for (int n = 0; n < 50; n++) begin
      @(posedge clock);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    nt = merge(tim_m, d, s) & 32'hFFFF_FFFB;
    if (a == `DCTC_TIM_OFS && cfg_m[15]) begin
      if (cfg_m[0] && nt[18:16] != tim_m[18:16]) exp_inits++;
      tim_m = nt;
    end else if (a == `DCTC_CFG_OFS) cfg_m = merge(cfg_m, d, s) & 32'h0000_8001;
    else if (a == `DCTC_RFI_OFS) begin
      nt = merge(rfi_m, d, s) & 32'hFFFF;
      rfi_m = (nt < 32'h100) ? {24'h0, tim_m[31:25], 1'b0} : nt;
    end else if (a != `DCTC_STAT_OFS && a != `DCTC_TIM_OFS) er = `DCTC_RESP_ERR;
    check("bresp", er, bresp);
    @(posedge clock);
    check("init count", exp_inits, inits);
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a);
    logic [31:0] e;
    // Status shows all five timers expired; it is read only while no command is pending.
    e = (a == `DCTC_TIM_OFS) ? tim_m : (a == `DCTC_CFG_OFS) ? cfg_m :
      (a == `DCTC_STAT_OFS) ? 32'h0000_001F : rfi_m;
    @(posedge clock);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (int n = 0; n < 50; n++) begin
      @(posedge clock);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    check("rresp", (a > 8'h0C) ? `DCTC_RESP_ERR : `DCTC_RESP_OK, rresp);
    check("rdata", (a > 8'h0C) ? 32'h0 : e, rdata);
  endtask : rd_chk
  task automatic issue(input dctc_op_t op, input logic [2:0] b);
    @(posedge clock);
    req <= '{valid: 1'b1, op: op, bank: b};
    for (int n = 0; n < 400; n++) begin
      @(posedge clock);
      if (grant === 1'b1) break;
    end
    check("grant", 1, {grant, mvalid} == 2'b11);
    check("mem_cmd", {op, b}, mcmd);
    req <= '0;
  endtask : issue
  initial begin
    #(25 * 60000);
    fails++;
    summarize();
  end
  initial begin
    void'($urandom(72109));
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    for (int a = 0; a < 16; a += 4) rd_chk(8'(a));
    wr_reg(`DCTC_TIM_OFS, 32'h0, 4'hF);
    wr_reg(`DCTC_CFG_OFS, 32'h8000, 4'hF);
    // Software keeps row-active at or above activate-to-access.
    t[21:19] = 3'($urandom % 8);
    t = {7'($urandom % 6), 3'($urandom), t[21:19], 3'($urandom), 5'(t[21:19] + $urandom % 4),
      5'($urandom % 16), 3'($urandom), 1'b1, 2'($urandom)};
    wr_reg(`DCTC_TIM_OFS, t, 4'hF);
    wr_reg(`DCTC_CFG_OFS, 32'h8001, 4'hF);
    wr_reg(`DCTC_TIM_OFS, t, 4'hF);
    wr_reg(`DCTC_TIM_OFS, t ^ 32'h1_0000, 4'h4);
    wr_reg(`DCTC_TIM_OFS, 32'hFF, 4'h1);
    wr_reg(`DCTC_RFI_OFS, 32'hFF, 4'hF);
    check("rfi port", rfi_m, {16'h0, rfi});
    wr_reg(`DCTC_RFI_OFS, 32'h200, 4'h2);
    wr_reg(`DCTC_STAT_OFS, 32'hFFFF_FFFF, 4'hF);
    wr_reg(8'h40, 32'h1, 4'hF);
    wr_reg(`DCTC_CFG_OFS, 32'h0001, 4'hF);
    wr_reg(`DCTC_TIM_OFS, 32'h0, 4'hF);
    check("enable", 1, en);
    for (int a = 0; a < 16; a += 4) rd_chk(8'(a));
    rd_chk(8'h40);
    check("rfi port", rfi_m, {16'h0, rfi});
    @(posedge clock);
    req <= '{valid: 1'b1, op: OP_NOP, bank: 3'h1};
    repeat (5) begin
      @(posedge clock);
      check("nop grant", 0, grant);
    end
    req <= '0;
    issue(OP_LOAD_MODE, 0);
    issue(OP_REFRESH, 0);
    issue(OP_ACTIVATE, 2);
    issue(OP_ACTIVATE, 5);
    issue(OP_WRITE, 2);
    issue(OP_READ, 2);
    issue(OP_PRECHARGE, 2);
    issue(OP_ACTIVATE, 2);
    repeat (60) issue(dctc_op_t'($urandom_range(1, 6)), 3'($urandom));
    repeat (20) @(posedge clock);
    rd_chk(`DCTC_STAT_OFS);
    check("sdram spacing", 0, viol);
    summarize();
  end
endmodule : ddr2_command_timing_config_bench
`default_nettype wire
